// *** hw/adc_readout_pkg.sv ***
// Shared constants and types for the converter readout block.
// Assumes a 100 MHz core clock; the conversion cycle count below derives from it.
package adc_readout_pkg;

  // ************************************************************
  // Widths
  // ************************************************************
  localparam int RESULT_W = 18;
  localparam int FRAME_W  = 19;
  localparam int CNT_W    = 6;
  localparam int CONV_W   = 10;

  // ************************************************************
  // Timing
  // ************************************************************
  // Nominal conversion time; any value between the minimum and maximum works
  localparam int CORE_CLK_MHZ = 100;
  localparam int T_CONV_NS    = 700;
  localparam int CONV_CYCLES  = (T_CONV_NS * CORE_CLK_MHZ) / 1000;
  localparam logic [CONV_W-1:0] CONV_LAST = CONV_W'(CONV_CYCLES - 1);

  // ************************************************************
  // Frame lengths in shift-clock falling edges
  // ************************************************************
  localparam logic [CNT_W-1:0] LEN_PLAIN = 6'h12;
  localparam logic [CNT_W-1:0] LEN_BUSY  = 6'h13;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [CNT_W-1:0]    CNT_RST    = 6'h00;
  localparam logic [CONV_W-1:0]   CONV_RST   = 10'h000;
  localparam logic [FRAME_W-1:0]  FRAME_RST  = 19'h00000;
  localparam logic [RESULT_W-1:0] RESULT_RST = 18'h00000;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CONV,
    ST_WAIT_SEL,
    ST_SEND,
    ST_DONE
  } conv_state_e;

endpackage

// *** hw/bit_sync.sv ***
// Two-flop synchroniser for a group of independent levels or gray words.
// Assumes each bit may change at any time relative to clk_i.
`timescale 1ns/1ns
`default_nettype none

module bit_sync
  import adc_readout_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] hold_r;
  logic [WIDTH-1:0] hold_nxt;

  // First stage feeds only the second stage
  always_comb begin
    meta_nxt = rst_i ? '0 : async_i;
    hold_nxt = rst_i ? '0 : meta_r;
  end

  always_ff @(posedge clk_i) begin
    meta_r <= meta_nxt;
    hold_r <= hold_nxt;
  end

  assign sync_o = hold_r;

endmodule
`default_nettype wire

// *** hw/link_shift.sv ***
// Shift-clock side of the readout: counts falling edges and presents bits.
// Assumes frame_i and base_i are held steady by the core while a frame runs.
`timescale 1ns/1ns
`default_nettype none

module link_shift
  import adc_readout_pkg::*;
(
  input  wire logic               sclk_i,
  input  wire logic               sys_rst_i,
  input  wire logic [CNT_W-1:0]   base_i,
  input  wire logic [FRAME_W-1:0] frame_i,
  output logic      [CNT_W-1:0]   cnt_gray_o,
  output logic                    dout_o
);

  logic             rst_meta_r;
  logic             rst_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [CNT_W-1:0] gray_r;
  logic [CNT_W-1:0] gray_nxt;
  logic [CNT_W-1:0] idx;
  logic             bit_r;
  logic             bit_nxt;

  // ************************************************************
  // Reset brought into the shift-clock domain
  // ************************************************************
  always_ff @(negedge sclk_i) begin
    rst_meta_r <= sys_rst_i;
    rst_r      <= rst_meta_r;
  end

  // ************************************************************
  // Edge counter and next bit
  // ************************************************************
  // Free-running count; the core marks frame start by snapshotting it
  always_comb begin
    cnt_nxt  = rst_r ? CNT_RST : cnt_r + 6'h01;
    gray_nxt = cnt_nxt ^ (cnt_nxt >> 1);
    idx      = cnt_nxt - base_i;
    bit_nxt  = 1'b0;
    if (!rst_r && idx < CNT_W'(FRAME_W)) begin
      bit_nxt = frame_i[FRAME_W - 1 - int'(idx)];
    end
  end

  // Bits change only on falling edges, so both edges see them stable
  always_ff @(negedge sclk_i) begin
    cnt_r  <= cnt_nxt;
    gray_r <= gray_nxt;
    bit_r  <= bit_nxt;
  end

  assign cnt_gray_o = gray_r;
  // First bit needs no edge: it shows until the first falling edge
  assign dout_o = (cnt_r == base_i) ? frame_i[FRAME_W-1] : bit_r;

endmodule
`default_nettype wire

// *** hw/adc_serial_readout.sv ***
// Conversion control and chip-select serial readout of an 18-bit converter.
// Assumes sample_trigger_i, select_i and sclk_i come from the host's pins;
// sample_i is the converter core's result word on the core clock.
//
// How it works
// - Conversion timed internally; shift clock only reads
// - Result is 18-bit two's complement
// - Select level at trigger rise picks mode
// - Optional busy bit precedes the result bits
// - Trigger rise floats output, samples, converts
// - 3-wire conversion ignores later trigger level
// - 3-wire no-busy: trigger high at end
// - 3-wire trigger fall presents MSB, shift follows
// - 3-wire no-busy floats after 18 edges
// - 3-wire busy: trigger low at end
// - Busy mode drives low bit, then MSB-first
// - Busy mode floats after 19 edges
// - Bits stable across both shift-clock edges
// - 4-wire conversion ignores select level
// - 4-wire no-busy: select high at end
// - 4-wire select fall presents MSB, shift follows
// - 4-wire no-busy floats after 18 edges
// - 4-wire busy: select low at end
`timescale 1ns/1ns
`default_nettype none

module adc_serial_readout
  import adc_readout_pkg::*;
(
  input  wire logic                core_clk_i,
  input  wire logic                sys_rst_i,
  input  wire logic                sample_trigger_i,
  input  wire logic                select_i,
  input  wire logic                sclk_i,
  input  wire logic [RESULT_W-1:0] sample_i,
  output logic                     dout_o,
  output logic                     dout_oe_o
);

  localparam int CONV_DLY = CONV_CYCLES;

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [CNT_W+1:0] sync_in;
  logic [CNT_W+1:0] sync_out;
  logic             trig_s;
  logic             sel_s;
  logic [CNT_W-1:0] gray_s;
  logic [CNT_W-1:0] link_gray;

  assign sync_in = {sample_trigger_i, select_i, link_gray};
  assign trig_s  = sync_out[CNT_W+1];
  assign sel_s   = sync_out[CNT_W];
  assign gray_s  = sync_out[CNT_W-1:0];

  bit_sync #(
    .WIDTH (CNT_W + 2)
  ) u_sync (
    .clk_i   (core_clk_i),
    .rst_i   (sys_rst_i),
    .async_i (sync_in),
    .sync_o  (sync_out)
  );

  // Gray count back to binary edge count
  logic [CNT_W-1:0] cnt_bin;

  always_comb begin
    cnt_bin[CNT_W-1] = gray_s[CNT_W-1];
    for (int i = CNT_W - 2; i >= 0; i--) begin
      cnt_bin[i] = cnt_bin[i+1] ^ gray_s[i];
    end
  end

  // ************************************************************
  // Core state
  // ************************************************************
  conv_state_e         st_r;
  conv_state_e         st_nxt;
  logic [CONV_W-1:0]   conv_cnt_r;
  logic [CONV_W-1:0]   conv_cnt_nxt;
  logic [RESULT_W-1:0] result_r;
  logic [RESULT_W-1:0] result_nxt;
  logic [FRAME_W-1:0]  frame_r;
  logic [FRAME_W-1:0]  frame_nxt;
  logic [CNT_W-1:0]    base_r;
  logic [CNT_W-1:0]    base_nxt;
  logic                busy_mode_r;
  logic                busy_mode_nxt;
  logic                oe_r;
  logic                oe_nxt;
  logic                trig_d_r;
  logic                trig_d_nxt;
  logic [2:0]          settle_r;
  logic [2:0]          settle_nxt;

  logic                trig_rise;
  logic                conv_go;
  logic                sel_act;
  logic                conv_end;
  logic [CNT_W-1:0]    edges;
  logic [CNT_W-1:0]    frame_len;

  // Output is selected when trigger and select are not both high.
  // 3-wire: select tied high, trigger acts as chip select.
  // 4-wire: trigger held high, select acts as chip select.
  // Synchroniser comes out of reset low; an idle-high pin would look like a rise
  assign trig_rise = trig_s & ~trig_d_r & settle_r[2];
  assign conv_go   = trig_rise && (st_r != ST_CONV);
  assign sel_act   = ~(trig_s & sel_s);
  assign conv_end  = (st_r == ST_CONV) && (conv_cnt_r == CONV_LAST);
  assign edges     = cnt_bin - base_r;
  assign frame_len = busy_mode_r ? LEN_BUSY : LEN_PLAIN;

  // Next-state logic for conversion and readout
  always_comb begin
    st_nxt        = st_r;
    conv_cnt_nxt  = conv_cnt_r;
    result_nxt    = result_r;
    frame_nxt     = frame_r;
    base_nxt      = base_r;
    busy_mode_nxt = busy_mode_r;
    oe_nxt        = oe_r;
    trig_d_nxt    = trig_s;
    settle_nxt    = {settle_r[1:0], 1'b1};
    // A rise while converting is ignored, so the pin may select others
    if (conv_go) begin
      oe_nxt = 1'b0;
      if (sel_s) begin
        st_nxt       = ST_CONV;
        conv_cnt_nxt = CONV_RST;
        result_nxt   = sample_i;
      end else begin
        // Daisy-chain selected; not served by this block
        st_nxt = ST_IDLE;
      end
    end else begin
      case (st_r)
        ST_CONV: begin
          // Runs on core clock alone, whatever the pins do meanwhile
          conv_cnt_nxt = conv_cnt_r + 10'h001;
          if (conv_end) begin
            base_nxt = cnt_bin;
            if (sel_act) begin
              busy_mode_nxt = 1'b1;
              frame_nxt     = {1'b0, result_r};
              oe_nxt        = 1'b1;
              st_nxt        = ST_SEND;
            end else begin
              busy_mode_nxt = 1'b0;
              frame_nxt     = {result_r, 1'b0};
              st_nxt        = ST_WAIT_SEL;
            end
          end
        end
        ST_WAIT_SEL: begin
          // Select falling opens the frame with the MSB
          if (sel_act) begin
            base_nxt = cnt_bin;
            oe_nxt   = 1'b1;
            st_nxt   = ST_SEND;
          end
        end
        ST_SEND: begin
          // Float on the last edge or on deselect, whichever first
          if (!sel_act || edges >= frame_len) begin
            oe_nxt = 1'b0;
            st_nxt = ST_DONE;
          end
        end
        ST_DONE: begin
          st_nxt = ST_DONE;
        end
        ST_IDLE: begin
          st_nxt = ST_IDLE;
        end
        default: begin
          st_nxt = ST_IDLE;
          oe_nxt = 1'b0;
        end
      endcase
    end
  end

  // Register the core state
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      st_r        <= ST_IDLE;
      conv_cnt_r  <= CONV_RST;
      result_r    <= RESULT_RST;
      frame_r     <= FRAME_RST;
      base_r      <= CNT_RST;
      busy_mode_r <= 1'b0;
      oe_r        <= 1'b0;
      trig_d_r    <= 1'b0;
      settle_r    <= 3'h0;
    end else begin
      st_r        <= st_nxt;
      conv_cnt_r  <= conv_cnt_nxt;
      result_r    <= result_nxt;
      frame_r     <= frame_nxt;
      base_r      <= base_nxt;
      busy_mode_r <= busy_mode_nxt;
      oe_r        <= oe_nxt;
      trig_d_r    <= trig_d_nxt;
      settle_r    <= settle_nxt;
    end
  end

  assign dout_oe_o = oe_r;

  // ************************************************************
  // Shift-clock domain
  // ************************************************************
  // Frame word and base are quasi-static while the link reads them
  link_shift u_link (
    .sclk_i     (sclk_i),
    .sys_rst_i  (sys_rst_i),
    .base_i     (base_r),
    .frame_i    (frame_r),
    .cnt_gray_o (link_gray),
    .dout_o     (dout_o)
  );

  // ************************************************************
  // Checks
  // ************************************************************
  logic [CONV_W-1:0] age_r;

  // Cycles since the last conversion start, for the length check
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || (conv_go && sel_s)) begin
      age_r <= CONV_RST;
    end else begin
      age_r <= age_r + 10'h001;
    end
  end

  sequence s_start;
    conv_go && sel_s;
  endsequence

  sequence s_float;
    !dout_oe_o;
  endsequence

  property p_trig_float;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    conv_go |=> s_float;
  endproperty
  a_trig_float: assert property (p_trig_float) else $error("output not floated at trigger rise");

  property p_conv_len;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    s_start ##1 (st_r == ST_CONV)[*3] |-> ##(CONV_DLY - 3) conv_end;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

  property p_conv_age;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    conv_end |-> (age_r == CONV_LAST);
  endproperty
  a_conv_age: assert property (p_conv_age) else $error("conversion end at wrong age");

  property p_conv_ignores_pins;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (st_r == ST_CONV) && !conv_end |=> (st_r == ST_CONV);
  endproperty
  a_conv_ignores_pins: assert property (p_conv_ignores_pins) else $error("conversion aborted");

  property p_busy_bit;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    conv_end && sel_act && !trig_rise |=> dout_oe_o && !frame_r[FRAME_W-1] && busy_mode_r;
  endproperty
  a_busy_bit: assert property (p_busy_bit) else $error("busy bit missing");

  property p_no_busy;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    conv_end && !sel_act && !trig_rise |=> s_float ##0 (st_r == ST_WAIT_SEL);
  endproperty
  a_no_busy: assert property (p_no_busy) else $error("busy bit sent unasked");

  property p_msb_on_select;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (st_r == ST_WAIT_SEL) && sel_act && !trig_rise
      |=> dout_oe_o && (frame_r[FRAME_W-1] == result_r[RESULT_W-1]);
  endproperty
  a_msb_on_select: assert property (p_msb_on_select) else $error("MSB not presented");

  property p_deselect_float;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (st_r == ST_SEND) && !sel_act |=> s_float;
  endproperty
  a_deselect_float: assert property (p_deselect_float) else $error("output kept on deselect");

  property p_count_float;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (st_r == ST_SEND) && (edges == frame_len) |=> s_float ##1 s_float;
  endproperty
  a_count_float: assert property (p_count_float) else $error("output kept after last edge");

  property p_daisy_idle;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    conv_go && !sel_s |=> (st_r == ST_IDLE) && !dout_oe_o;
  endproperty
  a_daisy_idle: assert property (p_daisy_idle) else $error("daisy selection not idle");

  property p_frame_stable;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    dout_oe_o && $past(dout_oe_o) |-> $stable(frame_r) && $stable(base_r);
  endproperty
  a_frame_stable: assert property (p_frame_stable) else $error("frame changed mid read");

endmodule
`default_nettype wire

// *** sim/host_model.sv ***
// Host model: drives trigger, select and shift clock, reads the data pin.
// Assumes the bench resolves a floated data pin to its pull-up level.
`timescale 1ns/1ns
`default_nettype none

module host_model
  import adc_readout_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic               pin_i,
  input  wire logic               oe_i,
  output logic                    trig_o,
  output logic                    sel_o,
  output logic                    sclk_o,
  output logic                    stb_o,
  output logic      [FRAME_W-1:0] word_o,
  output int                      fault_o
);
  // ********
  // Idle pins
  // ********
  initial begin
    trig_o = 1'b1;
    sel_o = 1'b1;
    sclk_o = 1'b0;
    stb_o = 1'b0;
    word_o = '0;
    fault_o = 0;
  end

  // ********
  // Helpers
  // ********
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // Bounded wait; a miss is a fault, never a hang
  task automatic wait_oe(input logic lvl, input int lim);
    int i;
    i = 0;
    while (oe_i !== lvl && i < lim) begin
      tick(1);
      i++;
    end
    if (oe_i !== lvl) fault_o++;
  endtask

  // Shift clock only runs on request, so it stands still between frames
  task automatic pulse(input int n);
    repeat (n) begin
      #15 sclk_o = 1'b1;
      #15 sclk_o = 1'b0;
    end
  endtask

  // ********
  // One conversion and read
  // ********
  task automatic xfer(input bit four, input bit busy, input int m);
    logic b;
    int i;
    sel_o = 1'b1;
    trig_o = 1'b0;
    tick(3);
    trig_o = 1'b1;
    tick(10);
    if (four) sel_o = 1'b0; else trig_o = 1'b0;
    if (!busy) begin
      tick(5);
      if (four) sel_o = 1'b1; else trig_o = 1'b1;
    end
    // Output must stay floated while converting
    for (i = 0; i < 55; i++) begin
      tick(1);
      if (oe_i !== 1'b0) fault_o++;
    end
    if (busy) wait_oe(1'b1, 30);
    else begin
      tick(20);
      if (four) sel_o = 1'b0; else trig_o = 1'b0;
      wait_oe(1'b1, 6);
    end
    tick(5);
    word_o = '0;
    // Capture on the rise, confirm just before the fall
    for (i = 0; i < m; i++) begin
      #15 sclk_o = 1'b1;
      b = pin_i;
      #14 if (pin_i !== b) fault_o++;
      #1 sclk_o = 1'b0;
      word_o = {word_o[FRAME_W-2:0], b};
    end
    if (m < (busy ? 19 : 18)) begin
      if (four) sel_o = 1'b1; else trig_o = 1'b1;
    end
    wait_oe(1'b0, 8);
    sel_o = 1'b1;
    trig_o = 1'b1;
    stb_o = 1'b1;
    tick(1);
    stb_o = 1'b0;
  endtask

  // Select low at the trigger rise; the block must stay off the pin
  task automatic daisy(output int hits);
    hits = 0;
    sel_o = 1'b0;
    trig_o = 1'b0;
    tick(3);
    trig_o = 1'b1;
    repeat (100) begin
      tick(1);
      if (oe_i !== 1'b0) hits++;
    end
    sel_o = 1'b1;
  endtask
endmodule
`default_nettype wire

// *** sim/adc_serial_readout_tb_top.sv ***
// Testbench for the converter readout: host model on the pins, queued checks.
// Assumes a pull-up on the data pin, as with the busy bit used as interrupt.
`timescale 1ns/1ns
`default_nettype none

module adc_serial_readout_tb_top;
  import adc_readout_pkg::*;
  logic                core_clk;
  logic                sys_rst;
  logic                trig;
  logic                sel;
  logic                sclk;
  logic [RESULT_W-1:0] sample;
  logic                dout;
  logic                oe;
  logic                stb;
  logic [FRAME_W-1:0]  word;
  logic [FRAME_W-1:0]  exp;
  logic [FRAME_W-1:0]  q[$];
  wire logic           pin;
  int                  fault;
  int                  hits;
  int                  failures = 0;
  int                  n_checks = 0;

  // Pull-up wins whenever the block lets go
  assign pin = (oe === 1'b1) ? dout : 1'b1;

  adc_serial_readout uut (
    .core_clk_i(core_clk), .sys_rst_i(sys_rst), .sample_trigger_i(trig),
    .select_i(sel), .sclk_i(sclk), .sample_i(sample), .dout_o(dout), .dout_oe_o(oe)
  );

  host_model host (
    .clk_i(core_clk), .pin_i(pin), .oe_i(oe), .trig_o(trig), .sel_o(sel),
    .sclk_o(sclk), .stb_o(stb), .word_o(word), .fault_o(fault)
  );

  // ********
  // Clock and helpers
  // ********
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic check(input logic ok, input string what);
    n_checks++;
    if (ok !== 1'b1) begin
      failures++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask

  task automatic test_done;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Word changes after capture, so only the value at the rise may appear
  task automatic run(input bit four, input bit busy, input int m);
    logic [FRAME_W-1:0] full;
    sample = RESULT_W'($urandom);
    full = {1'b0, sample};
    q.push_back(full >> ((busy ? 19 : 18) - m));
    fork
      host.xfer(four, busy, m);
      begin
        tick(15);
        sample = RESULT_W'($urandom);
      end
    join
    // A 3-wire release restarts a conversion; let it finish
    tick(90);
  endtask

  // ********
  // Result watcher
  // ********
  always @(posedge core_clk) begin
    if (stb === 1'b1) begin
      exp = (q.size() > 0) ? q.pop_front() : 'x;
      n_checks++;
      if (word !== exp) begin
        failures++;
        $display("wrong value at %0t: frame %h want %h", $time, word, exp);
      end
    end
  end

  // ********
  // Main sequence
  // ********
  initial begin
    sys_rst = 1'b1;
    sample = '0;
    void'($urandom(40));
    // Shift-clock side needs its own edges to take the reset
    fork
      host.pulse(4);
      tick(13);
    join
    sys_rst = 1'b0;
    // Shift-clock reset releases only on its own edges; spend them before any frame
    host.pulse(3);
    tick(3);
    for (int f = 0; f < 2; f++) begin
      for (int b = 0; b < 2; b++) begin
        run(f[0], b[0], b ? 19 : 18);
        run(f[0], b[0], 1 + int'($urandom % 16));
      end
    end
    host.daisy(hits);
    check(hits == 0, "output driven in daisy selection");
    run(1'b0, 1'b0, 18);
    check(fault == 0, "pin timing or bit stability");
    tick(5);
    check(q.size() == 0, "frames missing");
    test_done;
  end

  // Cut a hang short
  initial begin
    #200000;
    failures++;
    test_done;
  end
endmodule
`default_nettype wire
